/* File: inc/swire_cfg.svh */
/*
  Timing constants for the single-wire bus master, regular and fast speed.
  Assumes a 40 MHz system clock (25 ns period).
*/
`ifndef SWIRE_CFG_SVH
`define SWIRE_CFG_SVH
`define CLK_PERIOD_NS 25
// Times in ns as printed; cycle counts derived below
`define RST_LOW_REG_NS 480000
`define RST_LOW_FAST_NS 48000
`define RST_LOW_FAST_MAX_NS 80000
`define RST_HIGH_REG_NS 480000
`define RST_HIGH_FAST_NS 48000
`define PRES_SAMPLE_REG_NS 70000
`define PRES_SAMPLE_FAST_NS 8500
`define SLOT_REG_NS 65000
`define SLOT_FAST_NS 8000
`define LOW1_REG_NS 6000
`define LOW1_FAST_NS 1000
`define RDV_REG_NS 15000
`define RDV_FAST_NS 2000
`define REC_REG_NS 5000
`define REC_FAST_NS 2000
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_MAX(ns) ((ns) / `CLK_PERIOD_NS)
// Read sample placed one cycle before the end of the valid window
`define RDV_REG_CYC (`CYC_MAX(`RDV_REG_NS) - 1)
`define RDV_FAST_CYC (`CYC_MAX(`RDV_FAST_NS) - 1)
`endif

/* File: inc/swire_pkg.sv */
/*
  Types for the single-wire bus master: ROM command codes and operations.
  Assumes swire_cfg.svh holds the timing counts.
*/
`default_nettype none
package swire_pkg;
  typedef logic [7:0] rom_cmd_t;
  localparam rom_cmd_t CMD_READ_ROM = 8'h33;
  localparam rom_cmd_t CMD_MATCH = 8'h55;
  localparam rom_cmd_t CMD_SEARCH = 8'hf0;
  localparam rom_cmd_t CMD_SKIP = 8'hcc;
  localparam rom_cmd_t CMD_FAST_SKIP = 8'h3c;
  localparam rom_cmd_t CMD_FAST_MATCH = 8'h69;
  localparam rom_cmd_t CMD_RESUME = 8'ha5;
  // Operation requested by the user side
  typedef enum logic [2:0] {
    OP_RESET,
    OP_WRITE_BIT,
    OP_READ_BIT,
    OP_WRITE_BYTE,
    OP_READ_BYTE,
    OP_SEARCH_BIT
  } op_e;
endpackage : swire_pkg
`default_nettype wire

/* File: hw/swire_slot.sv */
/*
  Single time-slot engine: drives the open-drain line for one reset or bit slot.
  Assumes the line input is synchronous to clk and pulled high externally.
*/
`default_nettype none
`include "swire_cfg.svh"
module swire_slot
  import swire_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic fast,
  input wire logic start,
  input wire logic isReset,
  input wire logic txBit,
  input wire logic lineIn,
  output logic lineOe,
  output logic busy,
  output logic done,
  output logic rxBit
);
  localparam int CW = 16;
  localparam logic [CW-1:0] RL_R = CW'(`CYC_MIN(`RST_LOW_REG_NS));
  localparam logic [CW-1:0] RL_F = CW'(`CYC_MIN(`RST_LOW_FAST_NS));
  localparam logic [CW-1:0] RH_R = CW'(`CYC_MIN(`RST_HIGH_REG_NS));
  localparam logic [CW-1:0] RH_F = CW'(`CYC_MIN(`RST_HIGH_FAST_NS));
  localparam logic [CW-1:0] PS_R = CW'(`CYC_MIN(`PRES_SAMPLE_REG_NS));
  localparam logic [CW-1:0] PS_F = CW'(`CYC_MIN(`PRES_SAMPLE_FAST_NS));
  localparam logic [CW-1:0] SL_R = CW'(`CYC_MIN(`SLOT_REG_NS));
  localparam logic [CW-1:0] SL_F = CW'(`CYC_MIN(`SLOT_FAST_NS));
  localparam logic [CW-1:0] L1_R = CW'(`CYC_MIN(`LOW1_REG_NS));
  localparam logic [CW-1:0] L1_F = CW'(`CYC_MIN(`LOW1_FAST_NS));
  localparam logic [CW-1:0] RV_R = CW'(`RDV_REG_CYC);
  localparam logic [CW-1:0] RV_F = CW'(`RDV_FAST_CYC);
  localparam logic [CW-1:0] RC_R = CW'(`CYC_MIN(`REC_REG_NS));
  localparam logic [CW-1:0] RC_F = CW'(`CYC_MIN(`REC_FAST_NS));

  logic [CW-1:0] cnt_r;
  logic active_r;
  logic rst_r;
  logic bit_r;
  logic rx_r;
  logic done_r;

  // Speed-selected limits
  wire [CW-1:0] lowEnd = rst_r ? (fast ? RL_F : RL_R) : (bit_r ? (fast ? L1_F : L1_R) : (fast ? SL_F : SL_R));
  wire [CW-1:0] sampAt = rst_r ? CW'(lowEnd + (fast ? PS_F : PS_R)) : (fast ? RV_F : RV_R);
  wire [CW-1:0] endAt = rst_r ? CW'(lowEnd + (fast ? RH_F : RH_R)) : (fast ? CW'(SL_F + RC_F) : CW'(SL_R + RC_R));
  wire sampleNow = active_r && (cnt_r == sampAt);
  wire finishNow = active_r && (cnt_r == endAt);

  // Master pulls the line low to open every slot and reset
  assign lineOe = active_r && (cnt_r < lowEnd);
  assign busy = active_r;
  assign done = done_r;
  assign rxBit = rx_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      active_r <= 1'b0;
      rst_r <= 1'b0;
      bit_r <= 1'b0;
      rx_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= finishNow;
      if (start && !active_r) begin
        active_r <= 1'b1;
        rst_r <= isReset;
        bit_r <= txBit;
        cnt_r <= '0;
      end else if (active_r) begin
        cnt_r <= CW'(cnt_r + 1'b1);
        if (sampleNow) begin
          // Reset: line low means presence; bit: level is the read bit
          rx_r <= rst_r ? !lineIn : lineIn;
        end
        if (finishNow) begin
          active_r <= 1'b0;
        end
      end
    end
  end
endmodule : swire_slot
`default_nettype wire

/* File: hw/swire_master.sv */
/*
  Single-wire bus master: reset/presence, bit and byte transfers, search
  triplets, speed tracking and registration CRC checking.
  Assumes one open-drain line with external pull-up; lineIn synchronous to clk.
*/
// Overview of operation
// - Fast address-match: send 69h, then 64-bit number at fast speed; match selects fast.
// - Master starts all signaling except the device's presence pulse.
// - Master opens each transaction with a reset low of minimum length, then listens.
// - Each slot starts with master driving low; device syncs to falling edge.
// - Master samples read data late within the read-valid window.
// - CRC sent true form over the first 56 bits; master checks it over all 64 bits.
// - Address-match with 64-bit number selects only the exact device.
// - Search: per bit read, read complement, master writes; mismatch drops out.
`default_nettype none
`include "swire_cfg.svh"
module swire_master
  import swire_pkg::*;
#(
  parameter int BYTE_BITS = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOe,
  input wire logic reqValid,
  output logic reqReady,
  input wire op_e reqOp,
  input wire logic [7:0] reqData,
  input wire logic fastReq,
  output logic rspValid,
  output logic [7:0] rspData,
  output logic presence,
  output logic fastMode,
  output logic crcOk
);
  if (BYTE_BITS != 8) begin : g_chk
    $error("swire_master supports only 8-bit bytes");
  end

  typedef enum {
    S_IDLE,
    S_SLOT,
    S_NEXT,
    S_DONE
  } state_e;

  state_e st_r, st_nxt;
  op_e op_r;
  logic [7:0] sh_r;
  logic [2:0] bitIdx_r;
  logic [1:0] phase_r;
  logic [1:0] tri_r;
  logic fast_r;
  logic slotFast;
  logic [7:0] crc_r;
  logic [7:0] rsp_r;
  logic rspv_r;
  logic pres_r;
  logic slotStart;
  logic slotBit;
  logic slotIsRst;
  logic slotBusy;
  logic slotDone;
  logic slotRx;
  logic slotOe;

  // CRC step for polynomial X^8 + X^5 + X^4 + 1, LSB first
  function automatic logic [7:0] crc8Step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc8Step = {fb, c[7:1]} ^ (fb ? 8'h0c : 8'h00);
  endfunction

  wire isByteOp = (op_r == OP_WRITE_BYTE) || (op_r == OP_READ_BYTE);
  wire isWrOp = (op_r == OP_WRITE_BIT) || (op_r == OP_WRITE_BYTE);
  wire lastBit = !isByteOp || (bitIdx_r == 3'h7);
  // Search triplet: read, read complement, then write chosen direction
  wire searchWrite = (op_r == OP_SEARCH_BIT) && (phase_r == 2'h2);
  wire searchDir = (tri_r == 2'b01) ? 1'b1 : ((tri_r == 2'b10) ? 1'b0 : sh_r[0]);
  // Reads release the line after the minimum low time, as a write-one does
  wire txNow = searchWrite ? searchDir : (isWrOp ? sh_r[0] : 1'b1);
  wire searchLast = (op_r != OP_SEARCH_BIT) || (phase_r == 2'h2);
  wire rxUsed = !isWrOp && !searchWrite && (op_r != OP_RESET);
  // A reset meant to drop fast speed must itself be regular length
  assign slotFast = fast_r && (fastReq || (op_r != OP_RESET));

  assign slotStart = (st_r == S_SLOT) && !slotBusy;
  assign slotBit = txNow;
  assign slotIsRst = (op_r == OP_RESET);
  // Open drain: only ever pulls low; the device's own presence pulse is only listened for
  assign lineOut = 1'b0;
  assign lineOe = slotOe;
  assign reqReady = (st_r == S_IDLE);
  assign rspValid = rspv_r;
  assign rspData = rsp_r;
  assign presence = pres_r;
  assign fastMode = fast_r;
  // Residue zero after all 64 bits means the true-form CRC matched
  assign crcOk = (crc_r == 8'h00);

  swire_slot u_slot (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .fast(slotFast),
    .start(slotStart),
    .isReset(slotIsRst),
    .txBit(slotBit),
    .lineIn(lineIn),
    .lineOe(slotOe),
    .busy(slotBusy),
    .done(slotDone),
    .rxBit(slotRx)
  );

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: if (reqValid) st_nxt = S_SLOT;
      S_SLOT: if (slotBusy) st_nxt = S_NEXT;
      S_NEXT: if (slotDone) st_nxt = (lastBit && searchLast) ? S_DONE : S_SLOT;
      S_DONE: st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= S_IDLE;
      op_r <= OP_RESET;
      sh_r <= 8'h00;
      bitIdx_r <= 3'h0;
      phase_r <= 2'h0;
      tri_r <= 2'h0;
      fast_r <= 1'b0;
      crc_r <= 8'h00;
      rsp_r <= 8'h00;
      rspv_r <= 1'b0;
      pres_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      rspv_r <= (st_r == S_DONE);
      if (st_r == S_IDLE && reqValid) begin
        op_r <= reqOp;
        sh_r <= reqData;
        bitIdx_r <= 3'h0;
        phase_r <= 2'h0;
        tri_r <= 2'h0;
        if (reqOp == OP_RESET) begin
          crc_r <= 8'h00;
        end
      end
      if (st_r == S_NEXT && slotDone) begin
        case (op_r)
          OP_RESET: begin
            pres_r <= slotRx;
          end
          OP_SEARCH_BIT: begin
            phase_r <= phase_r + 2'h1;
            if (phase_r != 2'h2) begin
              tri_r <= {slotRx, tri_r[1]};
            end else begin
              rsp_r <= {5'h00, searchDir, tri_r};
              crc_r <= crc8Step(crc_r, searchDir);
            end
          end
          default: begin
            bitIdx_r <= bitIdx_r + 3'h1;
            sh_r <= {slotRx, sh_r[7:1]};
            if (rxUsed) begin
              crc_r <= crc8Step(crc_r, slotRx);
            end
            if (lastBit) begin
              rsp_r <= isByteOp ? {slotRx, sh_r[7:1]} : {7'h00, slotRx};
            end
          end
        endcase
      end
      // Speed switches after the command byte, before the number is sent
      if (st_r == S_DONE && op_r == OP_WRITE_BYTE) begin
        if (sh_r == CMD_FAST_SKIP || sh_r == CMD_FAST_MATCH) begin
          fast_r <= 1'b1;
        end
      end
      if (st_r == S_DONE && op_r == OP_RESET) begin
        // Fast resets stay under the short limit so speed is kept
        fast_r <= fast_r && fastReq;
      end
    end
  end
endmodule : swire_master
`default_nettype wire

/* File: dv/swire_master_asserts.sv */
/* Protocol checker for swire_master; bound to every instance.
   Assumes ce high while traffic runs. */
`default_nettype none
module swire_master_asserts
  import swire_pkg::*;
#(parameter int BYTE_BITS = 8) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic lineIn,
  input wire logic lineOut,
  input wire logic lineOe,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire op_e reqOp,
  input wire logic [7:0] reqData,
  input wire logic fastReq,
  input wire logic rspValid,
  input wire logic [7:0] rspData,
  input wire logic presence,
  input wire logic fastMode,
  input wire logic crcOk
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] lowCnt_r;
  op_e lastOp_r;
  logic [7:0] lastData_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt_r <= 16'h0000;
      lastOp_r <= OP_RESET;
      lastData_r <= 8'h00;
    end else begin
      lowCnt_r <= lineOe ? lowCnt_r + 16'h0001 : 16'h0000;
      if (reqValid && reqReady && ce) begin
        lastOp_r <= reqOp;
        lastData_r <= reqData;
      end
    end
  end
  sequence s_take_rst; reqValid && reqReady && ce && reqOp == OP_RESET; endsequence
  sequence s_end_low; $fell(lineOe); endsequence
  property p_od_low; lineOut == 1'b0; endproperty
  a_od_low: assert property (p_od_low) else $error("line driven high");
  property p_idle_quiet; reqReady |-> !lineOe; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("line pulled while idle");
  property p_rst_start; s_take_rst |-> ##[1:3] lineOe; endproperty
  a_rst_start: assert property (p_rst_start) else $error("reset pulse late");
  property p_rst_len; s_end_low and lowCnt_r > 16'd4800 |-> lowCnt_r >= 16'd19200; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
  property p_fast_rst; s_end_low and fastMode && fastReq && lastOp_r == OP_RESET
    |-> lowCnt_r >= 16'd1920 && lowCnt_r <= 16'd3200; endproperty
  a_fast_rst: assert property (p_fast_rst) else $error("fast reset length");
  property p_slot_min; s_end_low |-> lowCnt_r >= 16'd40; endproperty
  a_slot_min: assert property (p_slot_min) else $error("slot low too short");
  property p_read_low; s_end_low and lastOp_r == OP_READ_BYTE
    |-> lowCnt_r <= 16'd600 && (!fastMode || lowCnt_r <= 16'd80); endproperty
  a_read_low: assert property (p_read_low) else $error("read low too long");
  property p_rsp_pulse; rspValid |=> !rspValid; endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer not a pulse");
  property p_fast_set; rspValid && lastOp_r == OP_WRITE_BYTE &&
    (lastData_r == CMD_FAST_SKIP || lastData_r == CMD_FAST_MATCH) |-> ##[0:1] fastMode; endproperty
  a_fast_set: assert property (p_fast_set) else $error("fast speed not set");
  property p_fast_clr; rspValid && lastOp_r == OP_RESET && !fastReq |-> ##[0:1] !fastMode; endproperty
  a_fast_clr: assert property (p_fast_clr) else $error("fast speed kept");
  property p_reg_rst; s_end_low and lastOp_r == OP_RESET && !fastReq |-> lowCnt_r >= 16'd19200; endproperty
  a_reg_rst: assert property (p_reg_rst) else $error("speed-clearing reset short");
endmodule // swire_master_asserts
bind swire_master swire_master_asserts #(.BYTE_BITS(BYTE_BITS)) i_chk (.clk(clk), .rst_b(rst_b), .ce(ce),
  .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe), .reqValid(reqValid), .reqReady(reqReady),
  .reqOp(reqOp), .reqData(reqData), .fastReq(fastReq), .rspValid(rspValid), .rspData(rspData),
  .presence(presence), .fastMode(fastMode), .crcOk(crcOk));
`default_nettype wire

/* File: dv/swire_dev_model.sv */
/* Behavioural slave device: reset/presence, speed, command byte, number read-out.
   Assumes the line is pulled up outside. */
`default_nettype none
module swire_dev_model
  import swire_pkg::*;
(
  input wire logic line,
  input wire logic [63:0] romId,
  output logic pull
);
  timeunit 1ns;
  timeprecision 100ps;
  logic fast;
  logic b;
  logic [7:0] cmd;
  int st;
  int cnt;
  realtime t0;
  realtime low;
  initial begin
    pull = 1'b0;
    fast = 1'b0;
    st = 0;
    cnt = 0;
    cmd = 8'h00;
    forever begin
      @(negedge line);
      t0 = $realtime;
      if (st == 2 && !romId[cnt]) begin
        pull = 1'b1;
        #(fast ? 3000 : 30000) pull = 1'b0;
      end else #(fast ? 3000 : 30000);
      b = line;
      if (line !== 1'b1) @(posedge line);
      low = $realtime - t0;
      if (low >= 480000) fast = 1'b0;
      if (low >= 480000 || (fast && low >= 48000)) begin
        #(fast ? 3000 : 30000) pull = 1'b1;
        #(fast ? 16000 : 120000) pull = 1'b0;
        st = 1;
        cnt = 0;
      end else if (st == 1) begin
        cmd = {b, cmd[7:1]};
        cnt++;
        if (cnt == 8) begin
          fast = fast | (cmd == CMD_FAST_SKIP);
          st = (cmd == CMD_READ_ROM) ? 2 : 0;
          cnt = 0;
        end
      end else if (st == 2) begin
        cnt++;
        if (cnt == 64) st = 0;
      end
    end
  end
endmodule // swire_dev_model
`default_nettype wire

/* File: dv/tb.sv */
/* Self-checking bench for swire_master against the device model.
   Assumes a 40 MHz clock and a pulled-up line. */
`default_nettype none
module tb
  import swire_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] dm; logic [7:0] de; logic [1:0] fm; logic [1:0] fe;} note_s;
  note_s notes[$];
  note_s nt;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic reqValid = 1'b0;
  logic fastReq = 1'b0;
  op_e reqOp = OP_RESET;
  logic [7:0] reqData = 8'h00;
  logic [63:0] romId = 64'h0;
  wire reqReady, lineOe, rspValid, presence, fastMode, crcOk, devPull;
  wire [7:0] rspData;
  wire lineLvl = !(lineOe | devPull);
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int seed;
  always #12.5 clk = ~clk;
  swire_master i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .lineIn(lineLvl), .lineOut(), .lineOe(lineOe),
    .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp), .reqData(reqData), .fastReq(fastReq),
    .rspValid(rspValid), .rspData(rspData), .presence(presence), .fastMode(fastMode), .crcOk(crcOk));
  swire_dev_model i_dev (.line(lineLvl), .romId(romId), .pull(devPull));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic op(input op_e o, input logic [7:0] d, dm, de, input logic [1:0] fm, fe);
    notes.push_back('{dm, de, fm, fe});
    @(posedge clk);
    reqValid <= 1'b1;
    reqOp <= o;
    reqData <= d;
    do @(negedge clk); while (reqReady !== 1'b1);
    @(posedge clk);
    reqValid <= 1'b0;
    do @(negedge clk); while (reqReady !== 1'b1);
    @(negedge clk);
  endtask
  // Reflected form of x^8+x^5+x^4+1, first bit in first
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
    return c;
  endfunction
  always @(negedge clk) begin
    if (rspValid === 1'b1) begin
      nt = notes.pop_front();
      check(rspData & nt.dm, nt.de);
      @(negedge clk);
      check({6'h00, {presence, fastMode} & nt.fm}, {6'h00, nt.fe});
    end
  end
  // Whole run is about 96k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 105000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    seed = $urandom(78330);
    romId[55:0] = 56'({$urandom, $urandom});
    romId[63:56] = crc8(romId[55:0]);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    op(OP_RESET, 8'h00, 8'h00, 8'h00, 2'b11, 2'b10);
    $display("test regular reset done");
    op(OP_WRITE_BYTE, CMD_FAST_SKIP, 8'h00, 8'h00, 2'b01, 2'b01);
    $display("test fast skip done");
    @(posedge clk);
    fastReq <= 1'b1;
    op(OP_RESET, 8'h00, 8'h00, 8'h00, 2'b11, 2'b11);
    $display("test fast reset done");
    op(OP_WRITE_BYTE, CMD_READ_ROM, 8'h00, 8'h00, 2'b01, 2'b01);
    for (int i = 0; i < 8; i++) op(OP_READ_BYTE, 8'($urandom), 8'hff, romId[8*i +: 8], 2'b01, 2'b01);
    check({7'h00, crcOk}, 8'h01);
    $display("test number read done");
    op(OP_READ_BIT, 8'h00, 8'hff, 8'h01, 2'b01, 2'b01);
    op(OP_WRITE_BIT, 8'h00, 8'h01, 8'h00, 2'b01, 2'b01);
    op(OP_SEARCH_BIT, 8'h01, 8'h07, 8'h07, 2'b01, 2'b01);
    $display("test bit ops done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
